// >>> pkg/dmx_pkg.sv
// Constants, opcodes, register map and state type for the move executor
package dmx_pkg;

  // Core clock and instruction cycle shape
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROC = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;

  // Opcode fields
  localparam logic [5:0] LOAD_POINTER_OPC = 6'h38;
  localparam logic [5:0] COPY_FILE_OPC = 6'h14;
  localparam logic [3:0] COPY_F2F_OPC = 4'hc;
  localparam logic [3:0] SECOND_WORD_OPC = 4'hf;
  localparam logic [7:0] LOAD_BANK_OPC = 8'h01;
  localparam logic [1:0] POINTER_SEL_BAD = 2'h3;

  // Addressing constants
  localparam int unsigned NUM_POINTERS = 3;
  localparam logic [1:0] INDEX_POINTER = 2'h2;
  localparam logic [7:0] EXT_INDEX_MAX = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [11:0] ACC_ADDR = 12'hfe8;

  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ACC = 12'h004;
  localparam logic [11:0] REG_BANK = 12'h008;
  localparam logic [11:0] REG_PTR0 = 12'h00c;
  localparam logic [11:0] REG_STRIDE = 12'h004;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_PTR = 12'h000;
  localparam logic [11:0] RST_ADDR = 12'h000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_FIRST = 2'b00,
    ST_POINTER_LOW = 2'b01,
    ST_COPY_DEST = 2'b11
  } dmx_state_t;

endpackage : dmx_pkg

// >>> rtl/dmx_exec.sv
// Executor for pointer load, file copy, file-to-file copy and bank load
//
// Function
// (RULE_01) Pointer load: two words, high then low
// (RULE_02) Pointer load opcode 1110 00, selector, literal
// (RULE_03) Copy-file destination bit picks accumulator or file
// (RULE_04) Copy-file decode, one cycle, sign/zero flags
// (RULE_05) Bank bit picks access bank or bank-select
// (RULE_06) Extended mode: low offsets use indexed pointer
// (RULE_07) File-to-file copy: read source, write destination
// (RULE_08) Accumulator usable as copy source or destination
// (RULE_09) Stream never targets pc or stack bytes; the code has no guard and writes any destination address
// (RULE_10) Bank load keeps upper four bits zero
// (RULE_11) Stray second word executes as no-operation
`timescale 1ns/1ps
`default_nettype none

module dmx_exec (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  output logic instr_ready_o,
  output logic [11:0] dmem_addr_o,
  output logic dmem_rd_o,
  input wire logic [7:0] dmem_rdata_i,
  output logic dmem_we_o,
  output logic [7:0] dmem_wdata_o
);

  logic [1:0] q;
  logic [1:0] next_q;
  dmx_pkg::dmx_state_t st;
  dmx_pkg::dmx_state_t next_st;
  logic act;
  logic next_act;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic [7:0] hold;
  logic [7:0] next_hold;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic flag_z;
  logic next_flag_z;
  logic flag_n;
  logic next_flag_n;
  logic [3:0] bank;
  logic [3:0] next_bank;
  logic [1:0] ptr_sel;
  logic [1:0] next_ptr_sel;
  logic [11:0] ptr [dmx_pkg::NUM_POINTERS];
  logic [11:0] next_ptr [dmx_pkg::NUM_POINTERS];
  logic addr_acc;
  logic next_addr_acc;
  logic [11:0] next_addr;
  logic next_rd;
  logic next_we;
  logic [7:0] next_wdata;
  logic ext_en;
  logic next_ext_en;
  logic [31:0] next_rdata;
  logic next_slverr;
  logic [7:0] move_val;
  logic [11:0] copy_addr;

  // Forms a file address from the 8-bit field and the bank bit
  function automatic logic [11:0] file_addr(
    input logic [7:0] f,
    input logic a,
    input logic ext,
    input logic [3:0] bank_select_reg,
    input logic [11:0] idx
  );
    logic [11:0] r;
    if (a) begin
      r = {bank_select_reg, f}; // see RULE_05
    end else if (ext && f <= dmx_pkg::EXT_INDEX_MAX) begin
      r = 12'(idx + {4'h0, f}); // see RULE_06
    end else if (f < dmx_pkg::ACCESS_SPLIT) begin
      r = {dmx_pkg::ACCESS_LOW_BANK, f}; // see RULE_05
    end else begin
      r = {dmx_pkg::ACCESS_HIGH_BANK, f};
    end
    return r;
  endfunction : file_addr

  // Words are only taken in the decode phase of each four-clock cycle
  assign instr_ready_o = (q == dmx_pkg::PH_DECODE);
  // No wait states: every register answers in its access cycle
  assign pready_o = 1'b1;

  // Address of a copy-file operand, used in the decode phase
  assign copy_addr = file_addr(instr_i[7:0], instr_i[8], ext_en, bank,
                               ptr[dmx_pkg::INDEX_POINTER]);

  // Value being moved; the accumulator stands in for memory at its address
  assign move_val = addr_acc ? acc : dmem_rdata_i; // see RULE_08

  // Sequencer and datapath next values
  always_comb begin
    next_q = 2'(q + 2'h1);
    next_st = st;
    next_act = act;
    next_ir = ir;
    next_hold = hold;
    next_acc = acc;
    next_flag_z = flag_z;
    next_flag_n = flag_n;
    next_bank = bank;
    next_ptr_sel = ptr_sel;
    next_ptr = ptr;
    next_addr_acc = addr_acc;
    next_addr = dmem_addr_o;
    next_rd = 1'b0;
    next_we = 1'b0;
    next_wdata = dmem_wdata_o;
    unique case (q)
      dmx_pkg::PH_DECODE: begin
        next_act = instr_valid_i;
        if (instr_valid_i) begin
          next_ir = instr_i;
          unique case (st)
            dmx_pkg::ST_FIRST: begin
              if (instr_i[15:10] == dmx_pkg::COPY_FILE_OPC) begin
                next_addr = copy_addr; // see RULE_04
                next_addr_acc = (copy_addr == dmx_pkg::ACC_ADDR);
                next_rd = (copy_addr != dmx_pkg::ACC_ADDR);
              end else if (instr_i[15:12] == dmx_pkg::COPY_F2F_OPC) begin
                next_addr = instr_i[11:0]; // see RULE_07
                next_addr_acc = (instr_i[11:0] == dmx_pkg::ACC_ADDR);
                next_rd = (instr_i[11:0] != dmx_pkg::ACC_ADDR);
              end
            end
            dmx_pkg::ST_COPY_DEST: begin
              // Destination cycle issues no dummy read
              next_addr = instr_i[11:0]; // see RULE_07
              next_addr_acc = (instr_i[11:0] == dmx_pkg::ACC_ADDR);
            end
            dmx_pkg::ST_POINTER_LOW: begin
              next_addr_acc = addr_acc;
            end
          endcase
        end
      end
      dmx_pkg::PH_PROC: begin
        if (act) begin
          unique case (st)
            dmx_pkg::ST_FIRST: begin
              if (ir[15:10] == dmx_pkg::LOAD_POINTER_OPC &&
                  ir[9:8] != dmx_pkg::POINTER_SEL_BAD) begin
                // High four bits first; no flags touched
                next_ptr[ir[9:8]][11:8] = ir[3:0]; // see RULE_01, RULE_02
                next_ptr_sel = ir[9:8];
                next_st = dmx_pkg::ST_POINTER_LOW;
              end else if (ir[15:10] == dmx_pkg::COPY_FILE_OPC) begin
                next_flag_z = (move_val == dmx_pkg::RST_BYTE); // see RULE_04
                next_flag_n = move_val[7];
                if (!ir[9] || addr_acc) begin
                  next_acc = move_val; // see RULE_03
                end else begin
                  next_we = 1'b1; // see RULE_03
                  next_wdata = move_val;
                end
              end else if (ir[15:12] == dmx_pkg::COPY_F2F_OPC) begin
                next_hold = move_val; // see RULE_07, RULE_08
                next_st = dmx_pkg::ST_COPY_DEST;
              end else if (ir[15:8] == dmx_pkg::LOAD_BANK_OPC) begin
                // Bank register is four bits wide, so k[7:4] never lands
                next_bank = ir[3:0]; // see RULE_10
              end else if (ir[15:12] == dmx_pkg::SECOND_WORD_OPC) begin
                // A lone second word changes nothing; a jump into the
                // middle of a two-word op must not corrupt state
                next_st = dmx_pkg::ST_FIRST; // see RULE_11
              end
              // Any other code idles for this cycle
            end
            dmx_pkg::ST_POINTER_LOW: begin
              next_ptr[ptr_sel][7:0] = ir[7:0]; // see RULE_01
              next_st = dmx_pkg::ST_FIRST;
            end
            dmx_pkg::ST_COPY_DEST: begin
              // No guard on pc or stack bytes, see RULE_09
              if (addr_acc) begin
                next_acc = hold; // see RULE_08
              end else begin
                next_we = 1'b1; // see RULE_07
                next_wdata = hold;
              end
              next_st = dmx_pkg::ST_FIRST;
            end
          endcase
        end
      end
      dmx_pkg::PH_READ,
      dmx_pkg::PH_WRITE: begin
        // Memory answers and writes land in these phases
        next_act = act;
      end
    endcase
  end

  // Sequencer and datapath registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= dmx_pkg::PH_DECODE;
      st <= dmx_pkg::ST_FIRST;
      act <= 1'b0;
      ir <= dmx_pkg::RST_WORD;
      hold <= dmx_pkg::RST_BYTE;
      acc <= dmx_pkg::RST_BYTE;
      flag_z <= 1'b0;
      flag_n <= 1'b0;
      bank <= dmx_pkg::RST_BANK;
      ptr_sel <= 2'h0;
      // All three pointers clear together
      for (int i = 0; i < dmx_pkg::NUM_POINTERS; i++) begin
        ptr[i] <= dmx_pkg::RST_PTR;
      end
      addr_acc <= 1'b0;
      dmem_addr_o <= dmx_pkg::RST_ADDR;
      dmem_rd_o <= 1'b0;
      dmem_we_o <= 1'b0;
      dmem_wdata_o <= dmx_pkg::RST_BYTE;
    end else begin
      q <= next_q;
      st <= next_st;
      act <= next_act;
      ir <= next_ir;
      hold <= next_hold;
      acc <= next_acc;
      flag_z <= next_flag_z;
      flag_n <= next_flag_n;
      bank <= next_bank;
      ptr_sel <= next_ptr_sel;
      ptr <= next_ptr;
      addr_acc <= next_addr_acc;
      dmem_addr_o <= next_addr;
      dmem_rd_o <= next_rd;
      dmem_we_o <= next_we;
      dmem_wdata_o <= next_wdata;
    end
  end

  // APB slave; read data is loaded in setup so it is stable in access
  always_comb begin
    next_ext_en = ext_en;
    next_rdata = prdata_o;
    next_slverr = pslverr_o;
    // Writes land only in the access cycle
    if (psel_i && penable_i && pwrite_i &&
        paddr_i == dmx_pkg::REG_CTRL) begin
      next_ext_en = pwdata_i[0];
    end
    if (psel_i && !penable_i) begin
      next_rdata = dmx_pkg::RST_RDATA;
      next_slverr = 1'b0;
      if (paddr_i == dmx_pkg::REG_CTRL) begin
        next_rdata[0] = ext_en;
      end else if (paddr_i == dmx_pkg::REG_ACC) begin
        next_rdata[9:0] = {flag_n, flag_z, acc};
      end else if (paddr_i == dmx_pkg::REG_BANK) begin
        next_rdata[3:0] = bank;
      end else begin
        // Unmapped unless one of the pointer words matches
        next_slverr = 1'b1;
        for (int i = 0; i < dmx_pkg::NUM_POINTERS; i++) begin
          if (paddr_i == 12'(dmx_pkg::REG_PTR0 + i * dmx_pkg::REG_STRIDE))
          begin
            next_rdata[11:0] = ptr[i];
            next_slverr = pwrite_i;
          end
        end
      end
      if (pwrite_i && paddr_i != dmx_pkg::REG_CTRL) begin
        next_slverr = 1'b1; // Status words are read only
      end
    end
  end

  // APB registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_en <= 1'b0;
      prdata_o <= dmx_pkg::RST_RDATA;
      pslverr_o <= 1'b0;
    end else begin
      ext_en <= next_ext_en;
      prdata_o <= next_rdata;
      pslverr_o <= next_slverr;
    end
  end

endmodule : dmx_exec

`default_nettype wire

// >>> dv/dmx_exec_properties.sv
// Port checker for the move executor
`timescale 1ns/1ps
`default_nettype none
module dmx_exec_properties (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pslverr_o,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic [11:0] dmem_addr_o,
  input wire logic dmem_rd_o,
  input wire logic [7:0] dmem_rdata_i,
  input wire logic dmem_we_o,
  input wire logic [7:0] dmem_wdata_o
);
  // Reset seen one edge late, so the release edge starts no attempt
  logic srst_q = 1'b1;
  always @(posedge clk_i) srst_q <= srst_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i || srst_q);
  // Taken word; copies that stay clear of the accumulator address
  wire take = instr_valid_i && instr_ready_o;
  wire cf = take && instr_i[15:10] == dmx_pkg::COPY_FILE_OPC
    && instr_i[8] && instr_i[7:0] != 8'he8;
  wire ff = take && instr_i[15:12] == dmx_pkg::COPY_F2F_OPC
    && instr_i[11:0] != dmx_pkg::ACC_ADDR;
  property p_cycle;
    instr_ready_o |=> !instr_ready_o [*3] ##1 instr_ready_o;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle length");
  property p_rd_slot;
    dmem_rd_o |-> $past(instr_ready_o);
  endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("read slot");
  property p_we_slot;
    dmem_we_o |-> $past(instr_ready_o, 3);
  endproperty
  a_we_slot: assert property (p_we_slot) else $error("write slot");
  property p_bank;
    take && instr_i[15:8] == dmx_pkg::LOAD_BANK_OPC |=> !dmem_rd_o ##2 !dmem_we_o;
  endproperty
  a_bank: assert property (p_bank) else $error("bank load hit memory");
  property p_ptr;
    take && instr_i[15:10] == dmx_pkg::LOAD_POINTER_OPC
      |=> !dmem_rd_o ##2 !dmem_we_o;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load hit memory");
  property p_cf_read;
    cf |=> dmem_rd_o && dmem_addr_o[7:0] == $past(instr_i[7:0]);
  endproperty
  a_cf_read: assert property (p_cf_read) else $error("copy read");
  property p_cf_back;
    cf && instr_i[9] |-> ##3 dmem_we_o && dmem_wdata_o == $past(dmem_rdata_i);
  endproperty
  a_cf_back: assert property (p_cf_back) else $error("write back");
  property p_ff_src;
    ff |=> dmem_rd_o && dmem_addr_o == $past(instr_i[11:0]) ##2 !dmem_we_o;
  endproperty
  a_ff_src: assert property (p_ff_src) else $error("source read");
  // Main scenarios reached
  c_back: cover property (cf && instr_i[9]);
  c_ff: cover property (ff);
  c_err: cover property (pslverr_o);
endmodule : dmx_exec_properties
bind dmx_exec dmx_exec_properties u_dmx_exec_properties (.clk_i(clk_i),
  .srst_i(srst_i), .pslverr_o(pslverr_o), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .instr_ready_o(instr_ready_o),
  .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o),
  .dmem_rdata_i(dmem_rdata_i), .dmem_we_o(dmem_we_o),
  .dmem_wdata_o(dmem_wdata_o));
`default_nettype wire

// >>> dv/dmx_prog_mem.sv
// Program memory model feeding instruction words
`timescale 1ns/1ps
`default_nettype none
module dmx_prog_mem (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [15:0] word_o
);
  logic [15:0] q [64];
  logic [15:0] last = 16'h0000;
  int wp = 0;
  int rp = 0;
  // Idle bus shows the inverse of the last word, never a stale copy
  always_comb begin
    valid_o = rp != wp;
    word_o = valid_o ? q[rp[5:0]] : ~last;
  end
  // A word leaves only at the edge that takes it
  always @(posedge clk_i) begin
    if (valid_o && ready_i) begin
      last <= q[rp[5:0]];
      rp <= rp + 1;
    end
  end
  // Late pointer update keeps a push off the edge that samples it
  task push(input logic [15:0] w);
    q[wp[5:0]] = w;
    wp <= wp + 1;
  endtask : push
endmodule : dmx_prog_mem
`default_nettype wire

// >>> dv/dmx_exec_bench.sv
// Self-checking bench for the move executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module dmx_exec_bench;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o, rdv;
  logic pready_o, pslverr_o, instr_valid_i, instr_ready_o, errv;
  logic dmem_rd_o, dmem_we_o;
  logic [15:0] instr_i;
  logic [11:0] dmem_addr_o, last_wa;
  logic [7:0] dmem_rdata_i = 8'h00;
  logic [7:0] dmem_wdata_o;
  logic [7:0] mem [4096];
  int n_fail = 0;
  int compares = 0;
  int wcnt = 0;
  always #2 clk_i = ~clk_i;
  dmx_exec u_dmx_exec (.clk_i(clk_i), .srst_i(srst_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o),
    .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o),
    .dmem_rdata_i(dmem_rdata_i), .dmem_we_o(dmem_we_o),
    .dmem_wdata_o(dmem_wdata_o));
  dmx_prog_mem u_dmx_prog_mem (.clk_i(clk_i), .ready_i(instr_ready_o),
    .valid_o(instr_valid_i), .word_o(instr_i));
  // Data memory: data one clock after the read pulse, churning otherwise
  always @(posedge clk_i) begin
    dmem_rdata_i <= dmem_rd_o ? mem[dmem_addr_o] : ~dmem_rdata_i;
    if (dmem_we_o) begin
      mem[dmem_addr_o] <= dmem_wdata_o;
      last_wa <= dmem_addr_o;
      wcnt <= wcnt + 1;
    end
  end
  task report_and_stop;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // One APB transfer; a spare edge after release avoids double drives
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      k++;
      if (k > 20) begin
        n_fail++;
        report_and_stop;
      end
      @(posedge clk_i);
    end
    rdv = prdata_o;
    errv = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  // Offer one word after a delay, then let its cycle finish
  task exec(input logic [15:0] w, input int gap);
    int k;
    k = 0;
    repeat (gap) @(posedge clk_i);
    u_dmx_prog_mem.push(w);
    @(posedge clk_i);
    while (u_dmx_prog_mem.rp != u_dmx_prog_mem.wp) begin
      k++;
      if (k > 40) begin
        n_fail++;
        report_and_stop;
      end
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : exec
  task t_regs;
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, a[11:0], 32'h0000_0000);
      `CHK(rdv, 32'h0000_0000)
      `CHK(errv, 1'b0)
    end
    apb(1'b1, dmx_pkg::REG_BANK, 32'h0000_0003);
    `CHK(errv, 1'b1)
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK(errv, 1'b1)
    $display("t_regs done");
  endtask : t_regs
  task t_bank;
    mem[12'h533] = 8'h80;
    exec(16'h01a5, 0);
    apb(1'b0, dmx_pkg::REG_BANK, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0005)
    exec(16'h5333, 0);
    `CHK(last_wa, 12'h533)
    apb(1'b0, dmx_pkg::REG_ACC, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0200)
    $display("t_bank done");
  endtask : t_bank
  task t_copy;
    exec(16'h5133, 0);
    apb(1'b0, dmx_pkg::REG_ACC, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0280)
    exec(16'h5010, 3);
    apb(1'b0, dmx_pkg::REG_ACC, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0100)
    `CHK(wcnt, 1)
    $display("t_copy done");
  endtask : t_copy
  task t_ext;
    mem[12'h3b0] = 8'h7e;
    apb(1'b1, dmx_pkg::REG_CTRL, 32'h0000_0001);
    exec(16'he203, 0);
    exec(16'hf0ab, 6);
    apb(1'b0, 12'h014, 32'h0000_0000);
    `CHK(rdv, 32'h0000_03ab)
    exec(16'h5005, 0);
    apb(1'b0, dmx_pkg::REG_ACC, 32'h0000_0000);
    `CHK(rdv, 32'h0000_007e)
    apb(1'b1, dmx_pkg::REG_CTRL, 32'h0000_0000);
    $display("t_ext done");
  endtask : t_ext
  task t_f2f;
    mem[12'h123] = 8'h5a;
    exec(16'hc123, 0);
    exec(16'hf456, 9);
    `CHK(mem[12'h456], 8'h5a)
    exec(16'hcfe8, 0);
    exec(16'hf200, 0);
    `CHK(mem[12'h200], 8'h7e)
    exec(16'hf777, 0);
    `CHK(wcnt, 3)
    $display("t_f2f done");
  endtask : t_f2f
  // Bad selector, pointer 0, high access bank, copy into accumulator
  task t_more;
    mem[12'hf90] = 8'hc3;
    exec(16'he30f, 0);
    exec(16'hf0cd, 0);
    exec(16'he001, 0);
    exec(16'hf022, 0);
    apb(1'b0, dmx_pkg::REG_PTR0, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0122)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0000)
    exec(16'h5090, 0);
    apb(1'b0, dmx_pkg::REG_ACC, 32'h0000_0000);
    `CHK(rdv, 32'h0000_02c3)
    exec(16'hc456, 0);
    exec(16'hffe8, 0);
    apb(1'b0, dmx_pkg::REG_ACC, 32'h0000_0000);
    `CHK(rdv, 32'h0000_025a)
    `CHK(wcnt, 3)
    $display("t_more done");
  endtask : t_more
  // Main sequence: clear memory, hold reset five clocks, run scenarios
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_bank;
    t_copy;
    t_ext;
    t_f2f;
    t_more;
    report_and_stop;
  end
endmodule : dmx_exec_bench
`default_nettype wire
